// ---- verilog/rtcc_top.sv ----
// Purpose: calendar clock with register port and one-second correction strobes
// Assumes: software keeps one strobe at a time and waits between corrections
// Notes: fields are binary; field writes load the clock and restart the second, correction writes do neither
//
// Decided for this implementation: the strobed register port.
`include "rtcc_consts.svh"
`timescale 1ns/10ps
`default_nettype none
// Contract
// - year, month, day, hour, minute, second readable and writable by software
// - a strobe adds or removes one second at the next seconds update
// - a strobe of any width that ends before the next seconds update yields exactly one correction
// - retard strobe is write-only bit 1 of the correction register
// - writing a field loads the clock, counting continues from there
// - year 00 is a leap year for February
// - hours 00 to 23, weekday 01 to 07 with 01 Sunday
module rtcc_top
   import rtcc_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = `RTCC_TICK_CYCLES
) (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic clk_en,
   input wire logic [15:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   output logic second_pulse
);
   // ****************************************************************
   // calendar state
   // ****************************************************************
   logic [5:0] clock_seconds;
   logic [5:0] clock_minutes;
   logic [4:0] clock_hours;
   logic [2:0] clock_weekday;
   logic [4:0] clock_day_of_month;
   logic [3:0] clock_month;
   logic [7:0] clock_year;
   logic [5:0] next_seconds;
   logic [5:0] next_minutes;
   logic [4:0] next_hours;
   logic [2:0] next_weekday;
   logic [4:0] next_day_of_month;
   logic [3:0] next_month;
   logic [7:0] next_year;
   rtcc_corr_t corr;
   rtcc_corr_t next_corr;
   logic [7:0] next_rdata;
   logic tick;
   logic any_load;
   logic corr_wr;
   logic [6:0] load_sel;
   logic tick_step;
   logic [5:0] step_seconds;
   logic sec_carry;
   logic min_carry;
   logic hr_carry;
   logic month_end;
   logic year_end;
   logic next_pulse;

   // days in a month; years divisible by four, 00 among them, are leap
   function automatic logic [4:0] days_in(input logic [3:0] mo, input logic [7:0] yr);
      logic leap;
      leap = (yr[1:0] == 2'b00);
      unique case (mo)
         4'h2: days_in = leap ? 5'h1D : 5'h1C;
         4'h4, 4'h6, 4'h9, 4'hB: days_in = 5'h1E;
         default: days_in = 5'h1F;
      endcase
   endfunction

   // one step up, back to lo once hi is reached
   // a value written above hi also comes back to lo at its next step
   function automatic logic [7:0] wrap_inc(input logic [7:0] v, input logic [7:0] lo,
      input logic [7:0] hi);
      logic [7:0] r;
      r = v + 8'h01;
      if (v >= hi) begin
         r = lo;
      end
      return r;
   endfunction

   // seconds after a tick: two steps under advance, none under retard
   function automatic logic [5:0] sec_after(input logic [5:0] s, input rtcc_corr_t c);
      logic [5:0] r;
      unique case (c)
         RTCC_ADV: r = (s >= 6'h3A) ? s - 6'h3A : s + 6'h02;
         RTCC_RET: r = s;
         default: r = (s >= 6'h3B) ? 6'h00 : s + 6'h01;
      endcase
      return r;
   endfunction

   // ****************************************************************
   // write decode
   // ****************************************************************
   // one select per field
   always_comb begin
      load_sel = 7'h00;
      corr_wr = 1'b0;
      if (wr) begin
         unique case (addr)
            `RTCC_ADDR_SEC: load_sel = 7'h01;
            `RTCC_ADDR_MIN: load_sel = 7'h02;
            `RTCC_ADDR_HR: load_sel = 7'h04;
            `RTCC_ADDR_DAY: load_sel = 7'h08;
            `RTCC_ADDR_DATE: load_sel = 7'h10;
            `RTCC_ADDR_MO: load_sel = 7'h20;
            `RTCC_ADDR_YR: load_sel = 7'h40;
            `RTCC_ADDR_CORR: corr_wr = 1'b1;
            default: load_sel = 7'h00;
         endcase
      end
      // any field write restarts the second
      any_load = |load_sel;
   end

   rtcc_tick #(
      .PERIOD(TICK_CYCLES)
   ) u_tick (
      .clock(clock),
      .arst_n(arst_n),
      .clk_en(clk_en),
      .restart(any_load),
      .tick(tick)
   );

   // ****************************************************************
   // correction request capture
   // ****************************************************************
   always_comb begin
      next_corr = corr;
      if (corr_wr) begin
         // each write cycle sets the request; a strobe held across an update sets it again
         // both bits set counts as retard
         if (wdata[`RTCC_CORR_RET_BIT]) begin
            next_corr = RTCC_RET;
         end else if (wdata[`RTCC_CORR_ADV_BIT]) begin
            next_corr = RTCC_ADV;
         end
      end else if (tick && !any_load) begin
         // a restarted second keeps the request for the next update
         next_corr = RTCC_IDLE;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         corr <= RTCC_IDLE;
      end else if (clk_en) begin
         corr <= next_corr;
      end
   end

   // ****************************************************************
   // time of day
   // ****************************************************************
   // a field write wins over a tick in the same cycle and restarts the second
   always_comb begin
      tick_step = tick && !any_load;
      step_seconds = sec_after(clock_seconds, corr);
      // retard leaves the seconds as they are, so it can never carry
      sec_carry = tick_step && (step_seconds < clock_seconds);
      min_carry = sec_carry && (clock_minutes >= 6'h3B);
      hr_carry = min_carry && (clock_hours >= 5'h17);
      next_seconds = clock_seconds;
      next_minutes = clock_minutes;
      next_hours = clock_hours;
      if (tick_step) begin
         next_seconds = step_seconds;
      end
      if (sec_carry) begin
         next_minutes = 6'(wrap_inc({2'b00, clock_minutes}, 8'h00, 8'h3B));
      end
      if (min_carry) begin
         next_hours = 5'(wrap_inc({3'b000, clock_hours}, 8'h00, 8'h17));
      end
      if (load_sel[0]) begin
         next_seconds = wdata[5:0];
      end
      if (load_sel[1]) begin
         next_minutes = wdata[5:0];
      end
      if (load_sel[2]) begin
         next_hours = wdata[4:0];
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         clock_seconds <= `RTCC_RST_SEC;
         clock_minutes <= `RTCC_RST_MIN;
         clock_hours <= `RTCC_RST_HR;
      end else if (clk_en) begin
         clock_seconds <= next_seconds;
         clock_minutes <= next_minutes;
         clock_hours <= next_hours;
      end
   end

   // ****************************************************************
   // calendar date
   // ****************************************************************
   // the date moves only on the carry out of the last hour
   always_comb begin
      month_end = hr_carry && (clock_day_of_month >= days_in(clock_month, clock_year));
      year_end = month_end && (clock_month >= 4'hC);
      next_weekday = clock_weekday;
      next_day_of_month = clock_day_of_month;
      next_month = clock_month;
      next_year = clock_year;
      if (hr_carry) begin
         next_weekday = 3'(wrap_inc({5'h00, clock_weekday}, 8'h01, 8'h07));
         next_day_of_month = clock_day_of_month + 5'h01;
      end
      if (month_end) begin
         // last day of the month, February by the leap
         next_day_of_month = 5'h01;
         next_month = 4'(wrap_inc({4'h0, clock_month}, 8'h01, 8'h0C));
      end
      if (year_end) begin
         next_year = clock_year + 8'h01;
      end
      if (load_sel[3]) begin
         next_weekday = wdata[2:0];
      end
      if (load_sel[4]) begin
         next_day_of_month = wdata[4:0];
      end
      if (load_sel[5]) begin
         next_month = wdata[3:0];
      end
      if (load_sel[6]) begin
         next_year = wdata;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         clock_weekday <= `RTCC_RST_DAY;
         clock_day_of_month <= `RTCC_RST_DATE;
         clock_month <= `RTCC_RST_MO;
         clock_year <= `RTCC_RST_YR;
      end else if (clk_en) begin
         clock_weekday <= next_weekday;
         clock_day_of_month <= next_day_of_month;
         clock_month <= next_month;
         clock_year <= next_year;
      end
   end

   // ****************************************************************
   // second pulse
   // ****************************************************************
   // marks the update edge, one cycle after the internal tick
   always_comb begin
      next_pulse = tick;
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         second_pulse <= 1'b0;
      end else if (clk_en) begin
         second_pulse <= next_pulse;
      end
   end

   // ****************************************************************
   // read port
   // ****************************************************************
   always_comb begin
      next_rdata = 8'h00;
      if (rd) begin
         unique case (addr)
            `RTCC_ADDR_SEC: next_rdata = {2'b00, clock_seconds};
            `RTCC_ADDR_MIN: next_rdata = {2'b00, clock_minutes};
            `RTCC_ADDR_HR: next_rdata = {3'b000, clock_hours};
            `RTCC_ADDR_DAY: next_rdata = {5'b00000, clock_weekday};
            `RTCC_ADDR_DATE: next_rdata = {3'b000, clock_day_of_month};
            `RTCC_ADDR_MO: next_rdata = {4'h0, clock_month};
            `RTCC_ADDR_YR: next_rdata = clock_year;
            `RTCC_ADDR_STAT: next_rdata = {6'h00, corr == RTCC_RET, corr == RTCC_ADV};
            default: next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rdata <= 8'h00;
      end else if (clk_en) begin
         rdata <= next_rdata;
      end
   end
endmodule
`default_nettype wire

// ---- verilog/rtcc_consts.svh ----
// Purpose: constants for the real-time clock calendar with second correction
// Assumes: 40 MHz clock, plain register port with byte addresses as printed
// Notes: register offsets, field positions, reset values and timing counts
`ifndef RTCC_CONSTS_SVH
`define RTCC_CONSTS_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define RTCC_ADDR_SEC 16'h2015
`define RTCC_ADDR_MIN 16'h2016
`define RTCC_ADDR_HR 16'h2017
`define RTCC_ADDR_DAY 16'h2018
`define RTCC_ADDR_DATE 16'h2019
`define RTCC_ADDR_MO 16'h201A
`define RTCC_ADDR_YR 16'h201B
`define RTCC_ADDR_CORR 16'h201C
`define RTCC_ADDR_STAT 16'h201D

// ****************************************************************
// field positions
// ****************************************************************
`define RTCC_CORR_ADV_BIT 0
`define RTCC_CORR_RET_BIT 1

// ****************************************************************
// reset values
// ****************************************************************
`define RTCC_RST_SEC 6'h00
`define RTCC_RST_MIN 6'h00
`define RTCC_RST_HR 5'h00
`define RTCC_RST_DAY 3'h1
`define RTCC_RST_DATE 5'h01
`define RTCC_RST_MO 4'h1
`define RTCC_RST_YR 8'h00

// ****************************************************************
// timing
// ****************************************************************
`define RTCC_CLK_HZ 40000000
`define RTCC_TICK_S 1
`define RTCC_TICK_CYCLES (`RTCC_CLK_HZ * `RTCC_TICK_S)

`endif

// ---- verilog/rtcc_pkg.sv ----
// Purpose: types for the real-time clock calendar
// Assumes: nothing beyond the constants header
// Notes: holds the correction state encoding
package rtcc_pkg;
   typedef enum logic [1:0] {
      RTCC_IDLE = 2'b00,
      RTCC_ADV = 2'b01,
      RTCC_RET = 2'b11
   } rtcc_corr_t;
endpackage

// ---- verilog/rtcc_tick.sv ----
// Purpose: one-second tick generator
// Assumes: clock enable freezes the count
// Notes: period is a parameter so simulation can shorten it
`timescale 1ns/10ps
`default_nettype none
module rtcc_tick #(
   parameter int unsigned PERIOD = 40000000
) (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic clk_en,
   input wire logic restart,
   output logic tick
);
   logic [25:0] count;
   logic [25:0] next_count;
   logic next_tick;

   always_comb begin
      next_count = count;
      next_tick = 1'b0;
      if (restart) begin
         next_count = 26'h0000000;
      end else if (count == 26'(PERIOD - 1)) begin
         next_count = 26'h0000000;
         next_tick = 1'b1;
      end else begin
         next_count = count + 26'h0000001;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         count <= 26'h0000000;
         tick <= 1'b0;
      end else if (clk_en) begin
         count <= next_count;
         tick <= next_tick;
      end
   end
endmodule
`default_nettype wire

// ---- test/rtcc_monitor.sv ----
// Purpose: port assertions for the calendar clock
// Assumes: TICK_CYCLES equals that of the bound instance
// Notes: bound to rtcc_top below
`timescale 1ns/10ps
`default_nettype none
module rtcc_monitor #(
   parameter int unsigned TICK_CYCLES = 20
) (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic clk_en,
   input wire logic [15:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [7:0] rdata,
   input wire logic second_pulse
);
   logic [31:0] gap;
   logic [31:0] next_gap;
   // cycles since last pulse, write or freeze
   always_comb begin
      next_gap = gap + 32'h1;
      if (second_pulse || wr || !clk_en) begin
         next_gap = 32'h0;
      end
   end
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         gap <= 32'h0;
      end else begin
         gap <= next_gap;
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);
   a_read_idle_zero: assert property (clk_en && !rd |=> rdata == 8'h00)
      else $error("read data not zero without read");
   a_corr_write_only: assert property (rd && clk_en && addr == 16'h201C |=> rdata == 8'h00)
      else $error("correction register read not zero");
   a_unmapped_zero: assert property (rd && clk_en && addr > 16'h201D |=> rdata == 8'h00)
      else $error("unmapped read not zero");
   a_sec_range: assert property (rd && clk_en && addr == 16'h2015 |=> rdata < 8'h3C)
      else $error("seconds out of range");
   a_hour_range: assert property (rd && clk_en && addr == 16'h2017 |=> rdata < 8'h18)
      else $error("hours out of range");
   a_pulse_single: assert property (second_pulse && clk_en |=> !second_pulse)
      else $error("second pulse longer than one cycle");
   a_pulse_gap: assert property ($fell(second_pulse) |-> !second_pulse [*8])
      else $error("second pulses too close");
   a_pulse_bound: assert property (gap <= TICK_CYCLES + 32'h4)
      else $error("second pulse missing");
   c_tick: cover property (second_pulse);
   c_advance: cover property (wr && addr == 16'h201C && wdata == 8'h01);
   c_retard: cover property (wr && addr == 16'h201C && wdata == 8'h02);
endmodule
bind rtcc_top rtcc_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_mon (
   .clock(clock), .arst_n(arst_n), .clk_en(clk_en), .addr(addr), .wdata(wdata),
   .wr(wr), .rd(rd), .rdata(rdata), .second_pulse(second_pulse));
`default_nettype wire

// ---- test/tb_top.sv ----
// Purpose: self-checking bench for the calendar clock
// Assumes: one second shortened to TICK cycles
// Notes: rows cover field access, hand tests cover carries and corrections
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   localparam int unsigned TICK = 20;
   logic clock, arst_n, clk_en, wr, rd, second_pulse;
   logic [15:0] addr;
   logic [7:0] wdata, rdata, v;
   int n_mismatch = 0;
   int n_checks = 0;
   int i;
   logic [7:0] rv [7] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};
   logic [31:0] rows [9] = '{32'h20152A2A, 32'h20163B3B, 32'h20171717, 32'h20180707,
      32'h20191F1F, 32'h201A0C0C, 32'h201B6363, 32'h201C0000, 32'h20205500};
   rtcc_top #(.TICK_CYCLES(TICK)) u_dut (.clock(clock), .arst_n(arst_n), .clk_en(clk_en),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .second_pulse(second_pulse));
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   // ****************************************************************
   // bus tasks
   // ****************************************************************
   task automatic chk(input string s, input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", s, exp, seen);
      end
   endtask
   task automatic put(input logic [15:0] a, input logic [7:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      rd <= 1'b0;
   endtask
   task automatic get(input logic [15:0] a);
      @(posedge clock);
      addr <= a;
      wr <= 1'b0;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      #1;
      v = rdata;
   endtask
   task automatic tick_wait;
      int k;
      @(posedge clock);
      wr <= 1'b0;
      #1;
      for (k = 0; k < 3 * TICK && second_pulse !== 1'b1; k++) begin
         @(posedge clock);
         #1;
      end
      chk("pulse", {7'h00, second_pulse}, 8'h01);
   endtask
   task automatic roll(input logic [7:0] mo, dt, yr, emo, edt, eyr);
      int k;
      logic [7:0] e [7];
      e = '{8'h00, 8'h00, 8'h00, 8'h01, edt, emo, eyr};
      put(16'h201B, yr);
      put(16'h201A, mo);
      put(16'h2019, dt);
      put(16'h2018, 8'h07);
      put(16'h2017, 8'h17);
      put(16'h2016, 8'h3B);
      put(16'h2015, 8'h3B);
      tick_wait;
      for (k = 0; k < 7; k++) begin
         get(16'h2015 + k[15:0]);
         chk("roll", v, e[k]);
      end
      $display("test roll done");
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      #200000;
      n_mismatch++;
      final_report;
   end
   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      arst_n = 1'b0;
      clk_en = 1'b1;
      addr = 16'h0000;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      repeat (16) @(posedge clock);
      arst_n <= 1'b1;
      for (i = 0; i < 7; i++) begin
         get(16'h2015 + i[15:0]);
         chk("reset", v, rv[i]);
      end
      $display("test reset done");
      for (i = 0; i < 9; i++) begin
         put(rows[i][31:16], rows[i][15:8]);
         get(rows[i][31:16]);
         chk("rw", v, rows[i][7:0]);
      end
      $display("test rows done");
      roll(8'h02, 8'h1C, 8'h00, 8'h02, 8'h1D, 8'h00);
      roll(8'h02, 8'h1C, 8'h01, 8'h03, 8'h01, 8'h01);
      roll(8'h0C, 8'h1F, 8'h0F, 8'h01, 8'h01, 8'h10);
      // long strobe: two writes back to back
      put(16'h2015, 8'h0A);
      put(16'h201C, 8'h01);
      put(16'h201C, 8'h01);
      get(16'h201D);
      chk("adv_pend", v, 8'h01);
      tick_wait;
      get(16'h2015);
      chk("adv", v, 8'h0C);
      tick_wait;
      get(16'h2015);
      chk("adv_once", v, 8'h0D);
      tick_wait;
      put(16'h201C, 8'h02);
      get(16'h201D);
      chk("ret_pend", v, 8'h02);
      tick_wait;
      get(16'h2015);
      chk("ret", v, 8'h0E);
      get(16'h201D);
      chk("pend_clr", v, 8'h00);
      $display("test correction done");
      put(16'h2015, 8'h05);
      @(posedge clock);
      wr <= 1'b0;
      clk_en <= 1'b0;
      repeat (3 * TICK) @(posedge clock);
      clk_en <= 1'b1;
      get(16'h2015);
      chk("freeze", v, 8'h05);
      $display("test freeze done");
      final_report;
   end
endmodule
`default_nettype wire
